// *** dv/lbaa_top_bench.sv ***
// Purpose: Self-checking bench for the activity alarm.
// Assumes: Observation cycle shortened to 8 clocks.
// Notes: Events pulse mid-cycle so the exact tick edge never matters.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module lbaa_top_bench;
    import lbaa_pkg::*;
    logic clock;
    logic nrst;
    logic ref_fail;
    logic ref_erratic;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic alarm;
    logic irq;
    logic [2:0] ph;
    logic [31:0] q;
    logic [8:0] prev;
    int fail_count;
    int checked;
    // Row: event code [10:9], then alarm and count after that cycle.
    logic [10:0] rows [21] = '{11'h201, 11'h402, 11'h203, 11'h404, 11'h605, 11'h306,
        11'h507, 11'h308, 11'h508, 11'h108, 11'h107, 11'h107, 11'h308, 11'h108,
        11'h107, 11'h107, 11'h106, 11'h106, 11'h105, 11'h105, 11'h004};
    logic [7:0] rst_exp [9] = '{RST_RAISE, RST_CLEAR, {6'h00, RST_LEAK}, RST_SIZE,
        8'h00, 8'h00, {6'h00, RST_IRQ_MASK}, 8'h00, 8'h00};

    lbaa_top #(.TICK_CYCLES(8)) dut (
        .clock(clock), .nrst(nrst), .ref_fail(ref_fail), .ref_erratic(ref_erratic),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .alarm(alarm), .irq(irq)
    );

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Phase within the observation cycle; the tick lands near phase zero.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ph <= 3'h0;
        end else begin
            ph <= ph + 3'h1;
        end
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic wait_ph(input logic [2:0] p);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (ph != p && n < 16);
        if (ph != p) begin
            fail_count++;
            close_out();
        end
    endtask : wait_ph

    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rd_q);
        int n;
        @(posedge clock);
        avs_address <= a;
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= d;
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            close_out();
        end
        rd_q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [5:0] a);
        bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    endtask : rd

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF, q);
    endtask : wr

    task automatic pulse(input logic [1:0] ev);
        wait_ph(5);
        @(posedge clock);
        ref_fail <= ev[0];
        ref_erratic <= ev[1];
        @(posedge clock);
        ref_fail <= 1'b0;
        ref_erratic <= 1'b0;
    endtask : pulse

    initial begin
        nrst = 1'b0;
        ref_fail = 1'b0;
        ref_erratic = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        fail_count = 0;
        checked = 0;
        prev = 9'h000;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rd(6'(4 * i));
            `CHK(q, {24'h00_0000, rst_exp[i]})
        end
        for (int r = 0; r <= 21; r++) begin
            wait_ph(2);
            rd(OFS_STATE);
            `CHK(q, {23'h00_0000, prev})
            `CHK(alarm, prev[8])
            if (r < 21) begin
                pulse(rows[r][10:9]);
                prev = rows[r][8:0];
            end
        end
        // Both edges of the alarm are pending, masked off at first.
        rd(OFS_IRQ_STAT);
        `CHK(q, 32'h0000_0003)
        `CHK(irq, 1'b0)
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        repeat (3) @(negedge clock);
        `CHK(irq, 1'b1)
        wr(OFS_IRQ_STAT, 32'h0000_0001);
        repeat (3) @(negedge clock);
        `CHK(irq, 1'b0)
        rd(OFS_IRQ_STAT);
        `CHK(q, 32'h0000_0002)
        wr(OFS_IRQ_STAT, 32'h0000_0002);
        rd(OFS_IRQ_STAT);
        `CHK(q, 32'h0000_0000)
        wr(OFS_LEAK, 32'h0000_0000);
        repeat (6) wait_ph(2);
        rd(OFS_STATE);
        `CHK(q, 32'h0000_0000)
        for (int s = 0; s < 4; s++) begin
            wr(OFS_LEAK, 32'(s));
            pulse(2'h1);
            repeat (1 << s) wait_ph(2);
            rd(OFS_STATE);
            `CHK(q, 32'h0000_0001)
            wait_ph(2);
            rd(OFS_STATE);
            `CHK(q, 32'h0000_0000)
        end
        // Raise level zero flips the alarm up, then the clear level drops it.
        wr(OFS_RAISE, 32'h0000_0000);
        wait_ph(2);
        `CHK({alarm, irq}, 2'b11)
        wr(OFS_IRQ_MASK, 32'h0000_0002);
        wait_ph(2);
        `CHK({alarm, irq}, 2'b01)
        rd(OFS_IRQ_STAT);
        `CHK(q, 32'h0000_0003)
        wr(OFS_RAISE, 32'hFFFF_FF5A);
        rd(OFS_RAISE);
        `CHK(q, 32'h0000_005A)
        bus(1'b1, OFS_CLEAR, 32'h0000_0011, 4'hE, q);
        rd(OFS_CLEAR);
        `CHK(q, 32'h0000_0004)
        wr(OFS_STATE, 32'h0000_01FF);
        wr(6'h1C, 32'hFFFF_FFFF);
        rd(OFS_STATE);
        `CHK(q, 32'h0000_0000)
        rd(6'h1C);
        `CHK(q, 32'h0000_0000)
        @(posedge clock);
        nrst <= 1'b0;
        @(negedge clock);
        `CHK({avs_waitrequest, alarm, irq}, 3'b100)
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rd(OFS_RAISE);
        `CHK(q, 32'h0000_0006)
        close_out();
    end
endmodule : lbaa_top_bench

// *** dv/lbaa_top_monitor.sv ***
// Purpose: Port checker for the activity alarm.
// Assumes: One clock; TICK_CYCLES clocks per observation cycle.
// Notes: Bound to every lbaa_top below.
`timescale 1ns/1ps
module lbaa_top_monitor #(
    parameter int unsigned TICK_CYCLES = lbaa_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ref_fail,
    input wire logic ref_erratic,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic alarm,
    input wire logic irq
);
    // ----
    // History
    // ----
    logic alarm_ff;
    logic seen_ff;
    logic nxt_seen;
    logic [7:0] gap_ff;
    logic [7:0] nxt_gap;
    logic [2:0] ack_ff;
    logic [2:0] nxt_ack;
    logic [2:0] chg_ff;
    logic [2:0] nxt_chg;

    // The gap counter saturates so a full-length cycle never wraps it.
    always_comb begin
        nxt_seen = seen_ff | ref_fail | ref_erratic;
        nxt_gap = (gap_ff == 8'hFF) ? gap_ff : gap_ff + 8'h01;
        if (alarm != alarm_ff) begin
            nxt_gap = 8'h00;
        end
        nxt_ack = {ack_ff[1:0], ~avs_waitrequest};
        nxt_chg = {chg_ff[1:0], alarm != alarm_ff};
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            alarm_ff <= 1'b0;
            seen_ff <= 1'b0;
            gap_ff <= 8'hFF;
            ack_ff <= 3'h0;
            chg_ff <= 3'h0;
        end else begin
            alarm_ff <= alarm;
            seen_ff <= nxt_seen;
            gap_ff <= nxt_gap;
            ack_ff <= nxt_ack;
            chg_ff <= nxt_chg;
        end
    end

    // ----
    // Properties
    // ----
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    property p_rst;
        $rose(nrst) |-> avs_waitrequest && !alarm && !irq;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs active after reset");
    property p_ans;
        $rose(avs_read || avs_write) |=> !avs_waitrequest;
    endproperty
    a_ans: assert property (p_ans) else $error("access not answered in one cycle");
    property p_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_one: assert property (p_one) else $error("answer longer than one cycle");
    property p_idle;
        !(avs_read || avs_write) |=> avs_waitrequest;
    endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_top;
        !avs_waitrequest |-> avs_readdata[31:9] == 23'h00_0000;
    endproperty
    a_top: assert property (p_top) else $error("upper read bits not zero");
    property p_hold;
        (alarm != alarm_ff) |-> (gap_ff >= TICK_CYCLES - 1) || (gap_ff == 8'hFF);
    endproperty
    a_hold: assert property (p_hold) else $error("alarm moved within a cycle");
    property p_cause;
        $rose(alarm) |-> seen_ff;
    endproperty
    a_cause: assert property (p_cause) else $error("alarm with no event");
    property p_irq_up;
        $rose(irq) |-> (ack_ff != 3'h0) || (chg_ff != 3'h0) || (alarm != alarm_ff);
    endproperty
    a_irq_up: assert property (p_irq_up) else $error("irq rose without cause");
    property p_irq_dn;
        $fell(irq) |-> ack_ff != 3'h0;
    endproperty
    a_irq_dn: assert property (p_irq_dn) else $error("irq fell without access");

    c_alarm_up: cover property ($rose(alarm));
    c_alarm_dn: cover property ($fell(alarm));
    c_irq_up: cover property ($rose(irq));
    c_irq_dn: cover property ($fell(irq));
endmodule : lbaa_top_monitor

bind lbaa_top lbaa_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_monitor (
    .clock(clock), .nrst(nrst), .ref_fail(ref_fail), .ref_erratic(ref_erratic),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .alarm(alarm), .irq(irq)
);

// *** hdl/lbaa_bucket.sv ***
// Purpose: Leaky bucket accumulator with raise and clear hysteresis.
// Assumes: Inputs are sampled only on the observation cycle tick.
// Notes: The alarm follows the count of the same tick.
`timescale 1ns/1ps
module lbaa_bucket (
    input wire logic clock,
    input wire logic nrst,
    lbaa_ctl_if.core ctl
);
    import lbaa_pkg::*;

    logic [7:0] count_ff;
    logic [7:0] nxt_count;
    logic [2:0] leak_ff;
    logic [2:0] nxt_leak;
    logic alarm_ff;
    logic nxt_alarm;
    logic rose_ff;
    logic nxt_rose;
    logic fell_ff;
    logic nxt_fell;

    function automatic logic [3:0] group_len(input logic [1:0] sel);
        group_len = 4'h1 << sel;
    endfunction : group_len

    always_comb begin
        nxt_count = count_ff;
        nxt_leak = leak_ff;
        nxt_alarm = alarm_ff;
        nxt_rose = 1'b0;
        nxt_fell = 1'b0;
        if (ctl.tick) begin
            if (ctl.event_seen) begin
                nxt_leak = 3'h0;
                if (count_ff < ctl.size_limit) begin // RULE7
                    nxt_count = count_ff + 8'h01; // RULE2
                end else begin
                    nxt_count = ctl.size_limit; // RULE7
                end
            end else if ({1'b0, leak_ff} + 4'h1 >= group_len(ctl.leak_sel)) begin // RULE3
                nxt_leak = 3'h0;
                if (count_ff != 8'h00) begin // RULE7
                    nxt_count = count_ff - 8'h01; // RULE4
                end
            end else begin
                nxt_leak = leak_ff + 3'h1; // RULE3
            end
            if (!alarm_ff && nxt_count >= ctl.raise_level) begin // RULE5
                nxt_alarm = 1'b1;
                nxt_rose = 1'b1;
            end else if (alarm_ff && nxt_count <= ctl.clear_level) begin // RULE6
                nxt_alarm = 1'b0;
                nxt_fell = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_ff <= 8'h00;
            leak_ff <= 3'h0;
            alarm_ff <= 1'b0;
            rose_ff <= 1'b0;
            fell_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            leak_ff <= nxt_leak;
            alarm_ff <= nxt_alarm;
            rose_ff <= nxt_rose;
            fell_ff <= nxt_fell;
        end
    end

    assign ctl.count = count_ff;
    assign ctl.alarm = alarm_ff;
    assign ctl.alarm_rose = rose_ff;
    assign ctl.alarm_fell = fell_ff;

endmodule : lbaa_bucket

// *** hdl/lbaa_tick.sv ***
// Purpose: Free running observation cycle timer.
// Assumes: Period given in system clock cycles, at least two.
// Notes: Emits a one-cycle pulse at the end of each observation cycle.
`timescale 1ns/1ps
module lbaa_tick #(
    parameter int unsigned PERIOD = lbaa_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    output logic tick
);
    import lbaa_pkg::*;

    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    always_comb begin
        nxt_tick = 1'b0;
        nxt_cnt = cnt_ff + 32'h0000_0001;
        if (cnt_ff == 32'(PERIOD - 1)) begin // RULE1
            nxt_cnt = 32'h0000_0000;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule : lbaa_tick

// *** hdl/lbaa_top.sv ***
// Purpose: Leaky bucket activity alarm with Avalon-MM register slave.
// Assumes: Failure and erratic inputs are synchronous to clock.
// Notes: Every access answers after one wait cycle.
`timescale 1ns/1ps
// Function
// (RULE1) Evaluate input every 128 ms cycle.
// (RULE2) Add one per cycle with event.
// (RULE3) Clean cycles grouped by 1, 2, 4, 8.
// (RULE4) Subtract one per full clean group.
// (RULE5) Raise alarm when count reaches raise level.
// (RULE6) Clear alarm when count falls to clear.
// (RULE7) Count saturates at zero and size limit.
module lbaa_top #(
    parameter int unsigned TICK_CYCLES = lbaa_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ref_fail,
    input wire logic ref_erratic,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic alarm,
    output logic irq
);
    import lbaa_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    lbaa_ctl_if ctl ();

    logic tick;
    lbaa_bus_e state_ff;
    lbaa_bus_e nxt_state;
    logic wait_ff;
    logic nxt_wait;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [7:0] raise_ff;
    logic [7:0] nxt_raise;
    logic [7:0] clear_ff;
    logic [7:0] nxt_clear;
    logic [1:0] leak_ff;
    logic [1:0] nxt_leak;
    logic [7:0] size_ff;
    logic [7:0] nxt_size;
    logic [1:0] istat_ff;
    logic [1:0] nxt_istat;
    logic [1:0] imask_ff;
    logic [1:0] nxt_imask;
    logic irq_ff;
    logic nxt_irq;
    logic alarm_ff;
    logic nxt_alarm;
    logic pend_ff;
    logic nxt_pend;
    logic wr_commit;
    logic [1:0] irq_events;

    logic [1:0] istat_clr;
    logic wr_raise;
    logic wr_clear;
    logic wr_leak;
    logic wr_size;
    logic wr_imask;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Only byte lane 0 carries register data; a write without it is dropped.
    function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] ofs);
        reg_hit = (addr == ofs);
    endfunction : reg_hit

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    lbaa_tick #(
        .PERIOD(TICK_CYCLES)
    ) u_tick (
        .clock(clock),
        .nrst(nrst),
        .tick(tick)
    );

    lbaa_bucket u_bucket (
        .clock(clock),
        .nrst(nrst),
        .ctl(ctl)
    );

    // ------------------------------------------------------------------
    // Observation cycle event capture
    // ------------------------------------------------------------------
    // A failure seen on the tick cycle itself still counts toward the
    // cycle that is closing, so no event is lost at the boundary.
    assign ctl.tick = tick; // RULE1
    assign ctl.event_seen = pend_ff | ref_fail | ref_erratic; // RULE1
    assign ctl.raise_level = raise_ff;
    assign ctl.clear_level = clear_ff;
    assign ctl.leak_sel = leak_ff;
    assign ctl.size_limit = size_ff;

    always_comb begin
        nxt_pend = pend_ff | ref_fail | ref_erratic;
        if (tick) begin
            nxt_pend = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pend_ff <= 1'b0;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    // One wait cycle lets read data come from a flop at the cost of
    // halving peak bus throughput.
    always_comb begin
        nxt_state = state_ff;
        nxt_wait = wait_ff;
        nxt_rdata = rdata_ff;
        unique case (state_ff)
            LBAA_IDLE: begin
                if (avs_read || avs_write) begin
                    nxt_state = LBAA_ACK;
                    nxt_wait = 1'b0;
                    nxt_rdata = 32'h0000_0000;
                    if (avs_read) begin
                        unique case (avs_address)
                            OFS_RAISE: begin
                                nxt_rdata = {24'h00_0000, raise_ff};
                            end
                            OFS_CLEAR: begin
                                nxt_rdata = {24'h00_0000, clear_ff};
                            end
                            OFS_LEAK: begin
                                nxt_rdata = {30'h0000_0000, leak_ff};
                            end
                            OFS_SIZE: begin
                                nxt_rdata = {24'h00_0000, size_ff};
                            end
                            OFS_STATE: begin
                                nxt_rdata = {23'h00_0000, ctl.alarm, ctl.count};
                            end
                            OFS_IRQ_STAT: begin
                                nxt_rdata = {30'h0000_0000, istat_ff};
                            end
                            OFS_IRQ_MASK: begin
                                nxt_rdata = {30'h0000_0000, imask_ff};
                            end
                            default: begin
                                nxt_rdata = 32'h0000_0000;
                            end
                        endcase
                    end
                end
            end
            LBAA_ACK: begin
                nxt_state = LBAA_IDLE;
                nxt_wait = 1'b1;
            end
            default: begin
                nxt_state = LBAA_IDLE;
                nxt_wait = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_ff <= LBAA_IDLE;
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    // The write lands on the edge where the master sees waitrequest low.
    assign wr_commit = (state_ff == LBAA_ACK) && avs_write && avs_byteenable[0];

    // ------------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------------
    // Each strobe lasts only the answering cycle, so a request held
    // through its answering edge still writes exactly once.
    assign wr_raise = wr_commit && reg_hit(avs_address, OFS_RAISE);
    assign wr_clear = wr_commit && reg_hit(avs_address, OFS_CLEAR);
    assign wr_leak = wr_commit && reg_hit(avs_address, OFS_LEAK);
    assign wr_size = wr_commit && reg_hit(avs_address, OFS_SIZE);
    assign wr_imask = wr_commit && reg_hit(avs_address, OFS_IRQ_MASK);
    assign istat_clr = avs_writedata[1:0]
        & {2{wr_commit && reg_hit(avs_address, OFS_IRQ_STAT)}};

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_comb begin
        nxt_raise = raise_ff;
        nxt_clear = clear_ff;
        nxt_leak = leak_ff;
        nxt_size = size_ff;
        nxt_imask = imask_ff;
        if (wr_raise) begin
            nxt_raise = avs_writedata[7:0]; // RULE5
        end
        if (wr_clear) begin
            nxt_clear = avs_writedata[7:0]; // RULE6
        end
        if (wr_leak) begin
            nxt_leak = avs_writedata[1:0]; // RULE3
        end
        if (wr_size) begin
            nxt_size = avs_writedata[7:0]; // RULE7
        end
        if (wr_imask) begin
            nxt_imask = avs_writedata[1:0];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            raise_ff <= RST_RAISE;
            clear_ff <= RST_CLEAR;
            leak_ff <= RST_LEAK;
            size_ff <= RST_SIZE;
            imask_ff <= RST_IRQ_MASK;
        end else begin
            raise_ff <= nxt_raise;
            clear_ff <= nxt_clear;
            leak_ff <= nxt_leak;
            size_ff <= nxt_size;
            imask_ff <= nxt_imask;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // A new event in the clearing cycle keeps its bit set.
    assign irq_events[IRQ_RAISE_BIT] = ctl.alarm_rose;
    assign irq_events[IRQ_CLEAR_BIT] = ctl.alarm_fell;

    for (genvar b = 0; b < 2; b++) begin : g_istat
        always_comb begin
            nxt_istat[b] = istat_ff[b];
            if (istat_clr[b]) begin
                nxt_istat[b] = 1'b0;
            end
            if (irq_events[b]) begin
                nxt_istat[b] = 1'b1;
            end
        end

        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                istat_ff[b] <= 1'b0;
            end else begin
                istat_ff[b] <= nxt_istat[b];
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt and alarm output registers
    // ------------------------------------------------------------------
    always_comb begin
        nxt_irq = |(nxt_istat & nxt_imask);
        nxt_alarm = ctl.alarm;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_ff <= 1'b0;
            alarm_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
            alarm_ff <= nxt_alarm;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign alarm = alarm_ff;
    assign irq = irq_ff;

endmodule : lbaa_top

// *** pkg/lbaa_ctl_if.sv ***
// Purpose: Carrier between the register front end and the bucket core.
// Assumes: Single clock domain.
// Notes: Configuration flows to the core, state and events flow back.
`timescale 1ns/1ps
interface lbaa_ctl_if;
    logic tick;
    logic event_seen;
    logic [7:0] raise_level;
    logic [7:0] clear_level;
    logic [1:0] leak_sel;
    logic [7:0] size_limit;
    logic [7:0] count;
    logic alarm;
    logic alarm_rose;
    logic alarm_fell;

    modport front (
        output tick, event_seen, raise_level, clear_level, leak_sel, size_limit,
        input count, alarm, alarm_rose, alarm_fell
    );
    modport core (
        input tick, event_seen, raise_level, clear_level, leak_sel, size_limit,
        output count, alarm, alarm_rose, alarm_fell
    );
endinterface : lbaa_ctl_if

// *** pkg/lbaa_pkg.sv ***
// Purpose: Shared constants and types of the leaky bucket activity alarm.
// Assumes: 125 MHz system clock, 32-bit Avalon-MM register slave.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package lbaa_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_KHZ = 125000;
    localparam int unsigned CYCLE_MS = 128;
    localparam int unsigned TICK_CYCLES = CYCLE_MS * CLK_KHZ;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [5:0] OFS_RAISE = 6'h00;
    localparam logic [5:0] OFS_CLEAR = 6'h04;
    localparam logic [5:0] OFS_LEAK = 6'h08;
    localparam logic [5:0] OFS_SIZE = 6'h0C;
    localparam logic [5:0] OFS_STATE = 6'h10;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h14;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h18;

    localparam logic [7:0] RST_RAISE = 8'h06;
    localparam logic [7:0] RST_CLEAR = 8'h04;
    localparam logic [1:0] RST_LEAK = 2'h1;
    localparam logic [7:0] RST_SIZE = 8'h08;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;

    // State word: count in [7:0], alarm in bit 8.
    localparam int unsigned STATE_ALARM_BIT = 8;
    // Interrupt bits: alarm raised in bit 0, alarm cleared in bit 1.
    localparam int unsigned IRQ_RAISE_BIT = 0;
    localparam int unsigned IRQ_CLEAR_BIT = 1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LBAA_IDLE = 2'b01,
        LBAA_ACK = 2'b10
    } lbaa_bus_e;

endpackage : lbaa_pkg
